// ==== design/pie_pkg.sv ====
// Purpose: shared constants and types of the port input enable block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   register indices are kept as printed; byte address is index * 4
package pie_pkg;

  // bus widths and pin count
  localparam int unsigned PIE_ADDR_W = 16;
  localparam int unsigned PIE_DATA_W = 32;
  localparam int unsigned PIE_PINS   = 8;

  // register indices as printed
  localparam logic [13:0] PIE_IDX_C_EN  = 14'h30ba;
  localparam logic [13:0] PIE_IDX_D_EN  = 14'h30bb;
  // gated pin state of both ports
  localparam logic [13:0] PIE_IDX_STATE = 14'h30c0;

  // byte addresses derived from the indices
  localparam logic [15:0] PIE_ADDR_C_EN  = {PIE_IDX_C_EN, 2'b00};
  localparam logic [15:0] PIE_ADDR_D_EN  = {PIE_IDX_D_EN, 2'b00};
  localparam logic [15:0] PIE_ADDR_STATE = {PIE_IDX_STATE, 2'b00};

  // field layout of the state register
  localparam int unsigned PIE_STATE_C_LSB = 0;
  localparam int unsigned PIE_STATE_D_LSB = 8;

  // values after reset
  localparam logic [7:0] PIE_EN_RESET = 8'h00;

  // bus responses
  localparam logic [1:0] PIE_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PIE_RESP_SLVERR = 2'b10;

  // synchroniser stages ahead of the gated output register
  localparam int unsigned PIE_SYNC_STAGES = 2;

  // write channel states; only IDLE to HALF and HALF to RESP change one bit
  typedef enum logic [1:0] {
    PIE_W_IDLE = 2'b00,
    PIE_W_HALF = 2'b01,
    PIE_W_RESP = 2'b11
  } pie_wstate_type;

  // one register write as it leaves the bus slave
  typedef struct packed {
    logic [13:0] index;
    logic [7:0]  data;
    logic        lane0;
  } pie_wreq_type;

endpackage

// ==== design/pie_bank.sv ====
// Purpose: one port's input enable register and its gated input path
// Assumes: pins are asynchronous to aclk
// Notes:   the enable register is written only through wr_en
`timescale 1ns/1ps
module pie_bank
  import pie_pkg::*;
#(
  parameter int unsigned WIDTH = PIE_PINS
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // register write
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  // pins and results
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] en,
  output logic      [WIDTH-1:0] gated
);

  // refuse widths that the 8-bit register lane cannot carry, at elaboration
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("pie_bank: WIDTH must be 1 to 8");
  end

  // enable register, cleared by reset
  // reset clears enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en <= PIE_EN_RESET[WIDTH-1:0];
    end else if (wr_en) begin
      en <= wr_data;
    end
  end

  // per pin: two-stage synchroniser, then the enable gate
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic meta;   // first stage, read only by the second
      logic stable; // second stage
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta   <= 1'b0;
          stable <= 1'b0;
          gated[i] <= 1'b0;
        end else begin
          meta   <= pin_in[i];
          stable <= meta;
          // a clear bit blocks the pin, a set bit passes it
          gated[i] <= stable & en[i];
        end
      end
    end
  endgenerate

endmodule // pie_bank

// ==== design/pie_regs.sv ====
// Purpose: input enable registers of the third and fourth ports on AXI4-Lite
// Assumes: single clock aclk, synchronous active-low reset aresetn
// Notes:   one write and one read may run at the same time
// Contract
// - third port enable register at 0x30ba, 8 bits
// - third port: 0 disables, 1 enables input
// - third port register read/write, reads last write
// - fourth port enable register at 0x30bb, 8 bits
// - fourth port: 1 enables, 0 disables input
// - fourth port register read/write, reads last write
`timescale 1ns/1ps
module pie_regs
  import pie_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // write address channel
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [PIE_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  // write data channel
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [PIE_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // write response channel
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // read address channel
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [PIE_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  // read data channel
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [PIE_DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // third port pins
  input  wire logic [PIE_PINS-1:0]   third_port_pin_in,
  output logic [PIE_PINS-1:0]        third_port_in_en,
  output logic [PIE_PINS-1:0]        third_port_in_data,
  // fourth port pins
  input  wire logic [PIE_PINS-1:0]   fourth_port_pin_in,
  output logic [PIE_PINS-1:0]        fourth_port_in_en,
  output logic [PIE_PINS-1:0]        fourth_port_in_data
);

  // ---- write channel state ----
  pie_wstate_type            wstate;      // write channel state
  pie_wstate_type            next_wstate; // its next value
  logic                      aw_held;     // address captured, waiting for data
  logic                      w_held;      // data captured, waiting for address
  logic [13:0]               aw_index;    // captured word index
  logic [PIE_DATA_W-1:0]     w_data;      // captured write data
  logic [3:0]                w_strb;      // captured byte strobes

  // ---- handshake terms ----
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire  = s_axi_wvalid & s_axi_wready;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire b_fire  = s_axi_bvalid & s_axi_bready;
  wire r_fire  = s_axi_rvalid & s_axi_rready;

  // address and data take part once both halves are present
  wire have_aw = aw_held | aw_fire;
  wire have_w  = w_held | w_fire;
  wire do_wr   = have_aw & have_w & (wstate != PIE_W_RESP);

  // the current write, from the channel or from the holding registers
  pie_wreq_type wreq;
  assign wreq.index = aw_held ? aw_index : s_axi_awaddr[15:2];
  assign wreq.data  = w_held ? w_data[7:0] : s_axi_wdata[7:0];
  assign wreq.lane0 = w_held ? w_strb[0] : s_axi_wstrb[0];

  // ---- write decode ----
  wire wr_hit_c  = (wreq.index == PIE_IDX_C_EN);
  wire wr_hit_d  = (wreq.index == PIE_IDX_D_EN);
  wire wr_hit_st = (wreq.index == PIE_IDX_STATE);
  wire wr_mapped = wr_hit_c | wr_hit_d | wr_hit_st;
  wire wr_c      = do_wr & wr_hit_c & wreq.lane0;
  wire wr_d      = do_wr & wr_hit_d & wreq.lane0;

  // channel readies: each half is taken once per transaction
  assign s_axi_awready = (wstate != PIE_W_RESP) & ~aw_held;
  assign s_axi_wready  = (wstate != PIE_W_RESP) & ~w_held;

  // next write state
  always_comb begin
    next_wstate = wstate;
    case (wstate)
      PIE_W_IDLE: begin
        if (do_wr) begin
          next_wstate = PIE_W_RESP;
        end else if (aw_fire | w_fire) begin
          next_wstate = PIE_W_HALF;
        end
      end
      PIE_W_HALF: begin
        if (do_wr) begin
          next_wstate = PIE_W_RESP;
        end
      end
      PIE_W_RESP: begin
        if (b_fire) begin
          next_wstate = PIE_W_IDLE;
        end
      end
      default: begin
        next_wstate = PIE_W_IDLE;
      end
    endcase
  end

  // write state and holding registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate  <= PIE_W_IDLE;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      wstate  <= next_wstate;
      aw_held <= have_aw & ~do_wr;
      w_held  <= have_w & ~do_wr;
    end
  end

  // captured payloads, no reset needed
  always_ff @(posedge aclk) begin
    if (aw_fire) begin
      aw_index <= s_axi_awaddr[15:2];
    end
    if (w_fire) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  // write response: unmapped words answer with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= PIE_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bresp <= wr_mapped ? PIE_RESP_OKAY : PIE_RESP_SLVERR;
    end
  end
  assign s_axi_bvalid = (wstate == PIE_W_RESP);

  // ---- port banks ----
  logic [PIE_PINS-1:0] c_gated; // third port gated pins
  logic [PIE_PINS-1:0] d_gated; // fourth port gated pins

  pie_bank #(.WIDTH(PIE_PINS)) u_bank_c (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_c),
    .wr_data (wreq.data),
    .pin_in  (third_port_pin_in),
    .en      (third_port_in_en),
    .gated   (c_gated)
  );

  pie_bank #(.WIDTH(PIE_PINS)) u_bank_d (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr_en   (wr_d),
    .wr_data (wreq.data),
    .pin_in  (fourth_port_pin_in),
    .en      (fourth_port_in_en),
    .gated   (d_gated)
  );

  assign third_port_in_data  = c_gated;
  assign fourth_port_in_data = d_gated;

  // ---- read path ----
  wire [13:0] rd_index  = s_axi_araddr[15:2];
  wire        rd_hit_c  = (rd_index == PIE_IDX_C_EN);
  wire        rd_hit_d  = (rd_index == PIE_IDX_D_EN);
  wire        rd_hit_st = (rd_index == PIE_IDX_STATE);

  // state word: gated pins of both ports, upper bits zero
  wire [PIE_DATA_W-1:0] state_word =
    {16'h0000, d_gated, c_gated};

  // read mux, upper bits read as zero
  wire [PIE_DATA_W-1:0] rd_word =
    rd_hit_c  ? {24'h000000, third_port_in_en}  :
    rd_hit_d  ? {24'h000000, fourth_port_in_en} :
    rd_hit_st ? state_word : 32'h00000000;
  wire rd_mapped = rd_hit_c | rd_hit_d | rd_hit_st;

  // one read at a time: the address is refused while data waits
  assign s_axi_arready = ~s_axi_rvalid;

  // read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= PIE_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_mapped ? PIE_RESP_OKAY : PIE_RESP_SLVERR;
    end else if (r_fire) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---- checks ----
  // reads of each enable register
  wire rd_c = ar_fire & rd_hit_c;
  wire rd_d = ar_fire & rd_hit_d;

  // a write to a lane followed by its register update
  sequence s_wr_c;
    wr_c ##1 1'b1;
  endsequence

  sequence s_wr_d;
    wr_d ##1 1'b1;
  endsequence

  chk_c_write_lands: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_c |=> third_port_in_en == $past(wreq.data))
    else $error("third port enable not written");

  chk_d_write_lands: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_d |=> fourth_port_in_en == $past(wreq.data))
    else $error("fourth port enable not written");

  chk_c_readback: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_c |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(third_port_in_en)})
    else $error("third port readback wrong");

  chk_d_readback: assert property (
    @(posedge aclk) disable iff (!aresetn)
    rd_d |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(fourth_port_in_en)})
    else $error("fourth port readback wrong");

  // third port holds without a write
  chk_c_hold_value: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !wr_c |=> $stable(third_port_in_en))
    else $error("third port enable changed without a write");

  // fourth port register holds in the cycle after a write when no second write follows
  chk_d_write_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_d ##0 !wr_d |=> $stable(fourth_port_in_en))
    else $error("fourth port enable did not hold");

  // disabled third port pins read low, checked two cycles after an enable write
  chk_c_gate_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_wr_c |-> ##1 ((c_gated & ~$past(third_port_in_en)) == 8'h00))
    else $error("disabled third port pin passed");

  // disabled fourth port pins read low
  chk_d_gate_off: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> ((d_gated & ~$past(fourth_port_in_en)) == 8'h00))
    else $error("disabled fourth port pin passed");

  chk_reset_clear: assert property (
    @(posedge aclk)
    !aresetn |=> third_port_in_en == PIE_EN_RESET && fourth_port_in_en == PIE_EN_RESET)
    else $error("enables not cleared by reset");

  // response stays until taken
  chk_bresp_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  // read data stays until taken
  chk_rdata_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  // unmapped reads answer zero with a slave error
  chk_rd_unmapped: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ar_fire && !rd_mapped |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == PIE_RESP_SLVERR)
    else $error("unmapped read answered wrongly");

endmodule // pie_regs

// ==== bench/port_input_enable_regs_tb_top.sv ====
// Purpose: self-checking bench of the third and fourth port input enable registers
// Assumes: AXI4-Lite master tasks, one write or one read under way at a time
// Notes:   pin path is sampled after the sync and gating stages have settled
`timescale 1ns/1ps
module port_input_enable_regs_tb_top
  import pie_pkg::*;
;
  // clock, reset and bus master side
  logic                  aclk;
  logic                  aresetn;
  logic                  awvalid;
  logic                  awready;
  logic [PIE_ADDR_W-1:0] awaddr;
  logic                  wvalid;
  logic                  wready;
  logic [PIE_DATA_W-1:0] wdata;
  logic [3:0]            wstrb;
  logic                  bvalid;
  logic                  bready;
  logic [1:0]            bresp;
  logic                  arvalid;
  logic                  arready;
  logic [PIE_ADDR_W-1:0] araddr;
  logic                  rvalid;
  logic                  rready;
  logic [PIE_DATA_W-1:0] rdata;
  logic [1:0]            rresp;
  // pins of both ports
  logic [PIE_PINS-1:0]   c_pin;
  logic [PIE_PINS-1:0]   c_en;
  logic [PIE_PINS-1:0]   c_dat;
  logic [PIE_PINS-1:0]   d_pin;
  logic [PIE_PINS-1:0]   d_en;
  logic [PIE_PINS-1:0]   d_dat;
  // counters
  int                    err_count;
  int                    comparisons;
  // edges that bready or rready stay low once a request is taken
  int                    b_hold;
  int                    r_hold;
  // a byte address with no register behind its word index
  localparam logic [15:0] ADDR_HOLE = 16'hc2f0;

  pie_regs pie_regs_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .third_port_pin_in(c_pin), .third_port_in_en(c_en),
    .third_port_in_data(c_dat), .fourth_port_pin_in(d_pin),
    .fourth_port_in_en(d_en), .fourth_port_in_data(d_dat)
  );

  // free running bus clock, 40 ns period
  initial aclk = 1'b0;
  always #20 aclk = ~aclk;

  // comparisons, one per kind of result
  task automatic cmp_word(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic cmp_resp(input string what, input logic [1:0] e, input logic [1:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic cmp_pins(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  // verdict and end of run
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= (b_hold == 0);
    // only the watchdog ends a wait that never completes
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // a late bready keeps the response waiting for b_hold edges
    if (b_hold > 0) begin
      repeat (b_hold) @(posedge aclk);
      bready <= 1'b1;
      @(posedge aclk);
    end
    // bready is high now, so the edge seeing bvalid is the handshake
    while (bvalid !== 1'b1) begin
      @(posedge aclk);
    end
    cmp_resp("bresp", er, bresp);
  endtask

  // one read: address held until taken, data taken at the rvalid edge
  task automatic axi_read(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= (r_hold == 0);
    @(posedge aclk);
    while (arready !== 1'b1) begin
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    // a late rready keeps the read data waiting for r_hold edges
    if (r_hold > 0) begin
      repeat (r_hold) @(posedge aclk);
      rready <= 1'b1;
    end
    @(posedge aclk);
    while (rvalid !== 1'b1) begin
      @(posedge aclk);
    end
    cmp_word("rdata", ed, rdata);
    cmp_resp("rresp", er, rresp);
  endtask

  // drive pins and let them pass two syncs and the gating stage
  task automatic pins(input logic [7:0] c, input logic [7:0] d);
    c_pin <= c;
    d_pin <= d;
    repeat (4) @(posedge aclk);
  endtask

  // watchdog far beyond the fewer than a hundred cycles the tests take
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    conclude();
  end

  // main sequence
  initial begin
    err_count   = 0;
    comparisons = 0;
    b_hold      = 0;
    r_hold      = 0;
    aresetn = 1'b0;
    awvalid = 1'b0;
    awaddr  = '0;
    wvalid  = 1'b0;
    wdata   = '0;
    wstrb   = 4'h0;
    bready  = 1'b1;
    arvalid = 1'b0;
    araddr  = '0;
    rready  = 1'b1;
    c_pin   = 8'h00;
    d_pin   = 8'h00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // values after reset, pins high but gated off
    cmp_pins("third en", PIE_EN_RESET, c_en);
    cmp_pins("fourth en", PIE_EN_RESET, d_en);
    axi_read(PIE_ADDR_C_EN, 32'h00000000, PIE_RESP_OKAY);
    axi_read(PIE_ADDR_D_EN, 32'h00000000, PIE_RESP_OKAY);
    pins(8'hff, 8'hff);
    cmp_pins("third data", 8'h00, c_dat);
    cmp_pins("fourth data", 8'h00, d_dat);
    // distinct patterns, upper bits of the word dropped
    axi_write(PIE_ADDR_C_EN, 32'h000000a5, 4'h1, PIE_RESP_OKAY);
    axi_write(PIE_ADDR_D_EN, 32'hffffff3c, 4'hf, PIE_RESP_OKAY);
    axi_read(PIE_ADDR_C_EN, 32'h000000a5, PIE_RESP_OKAY);
    axi_read(PIE_ADDR_D_EN, 32'h0000003c, PIE_RESP_OKAY);
    cmp_pins("third en", 8'ha5, c_en);
    cmp_pins("fourth en", 8'h3c, d_en);
    cmp_pins("third data", 8'ha5, c_dat);
    cmp_pins("fourth data", 8'h3c, d_dat);
    axi_read(PIE_ADDR_STATE, 32'h00003ca5, PIE_RESP_OKAY);
    pins(8'h0f, 8'hf0);
    cmp_pins("third data", 8'h05, c_dat);
    cmp_pins("fourth data", 8'h30, d_dat);
    // a masked lane write leaves the third port register alone
    axi_write(PIE_ADDR_C_EN, 32'h000000ff, 4'he, PIE_RESP_OKAY);
    // the state word ignores writes
    axi_write(PIE_ADDR_STATE, 32'h0000ffff, 4'hf, PIE_RESP_OKAY);
    axi_read(PIE_ADDR_STATE, 32'h00003005, PIE_RESP_OKAY);
    // late ready on the response channels, answers must wait
    b_hold = 3;
    axi_write(ADDR_HOLE, 32'h000000ff, 4'hf, PIE_RESP_SLVERR);
    b_hold = 0;
    r_hold = 2;
    axi_read(ADDR_HOLE, 32'h00000000, PIE_RESP_SLVERR);
    r_hold = 0;
    axi_read(PIE_ADDR_C_EN, 32'h000000a5, PIE_RESP_OKAY);
    axi_read(PIE_ADDR_D_EN, 32'h0000003c, PIE_RESP_OKAY);
    // boundary values, all set and all clear
    axi_write(PIE_ADDR_C_EN, 32'h000000ff, 4'h1, PIE_RESP_OKAY);
    axi_write(PIE_ADDR_D_EN, 32'h00000000, 4'h1, PIE_RESP_OKAY);
    axi_read(PIE_ADDR_C_EN, 32'h000000ff, PIE_RESP_OKAY);
    axi_read(PIE_ADDR_D_EN, 32'h00000000, PIE_RESP_OKAY);
    cmp_pins("third data", 8'h0f, c_dat);
    cmp_pins("fourth data", 8'h00, d_dat);
    // reset in mid-run clears the enables again
    axi_write(PIE_ADDR_D_EN, 32'h00000081, 4'h1, PIE_RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp_pins("third en", PIE_EN_RESET, c_en);
    cmp_pins("fourth en", PIE_EN_RESET, d_en);
    axi_read(PIE_ADDR_C_EN, 32'h00000000, PIE_RESP_OKAY);
    axi_read(PIE_ADDR_D_EN, 32'h00000000, PIE_RESP_OKAY);
    conclude();
  end
endmodule // port_input_enable_regs_tb_top
